/* File: src/nv_store_pkg.sv */
package nv_store_pkg;

  // Signature row indexes for identification and calibration bytes.
  localparam logic [1:0] ID_ADDR_0 = 2'h0;
  localparam logic [1:0] ID_ADDR_1 = 2'h1;
  localparam logic [1:0] ID_ADDR_2 = 2'h2;
  localparam logic [1:0] CAL_ADDR_1MHZ = 2'h0;

  // Lock byte field positions and reset value.
  localparam int LOCK_BIT_ONE_POS = 0;
  localparam int LOCK_BIT_TWO_POS = 1;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [7:0] LOCK_UNUSED_MASK = 8'hFC;

  // High fuse byte field positions and reset value.
  localparam int BROWNOUT_ENABLE_POS = 0;
  localparam int BROWNOUT_LEVEL_POS = 1;
  localparam int EEPROM_RETAIN_POS = 2;
  localparam int SERIAL_PROG_ENABLE_POS = 3;
  localparam int RESET_PIN_DISABLE_POS = 4;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'hF7;
  localparam logic [7:0] FUSE_HIGH_UNUSED_MASK = 8'hE0;

  // Low fuse byte field positions and reset value.
  localparam int CLOCK_SOURCE_LSB = 0;
  localparam int STARTUP_TIME_LSB = 4;
  localparam int OSCILLATOR_OPTION_POS = 6;
  localparam int PLL_CLOCK_POS = 7;
  localparam logic [7:0] FUSE_LOW_RESET = 8'hE1;

  // Programmer command codes.
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
  localparam logic [7:0] CMD_READ_SIG = 8'h08;
  localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
  localparam logic [7:0] CMD_READ_FLASH = 8'h02;
  localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

  // Byte selects for fuse and lock access (req_i.sel).
  localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
  localparam logic [1:0] SEL_FUSE_HIGH = 2'h1;
  localparam logic [1:0] SEL_LOCK = 2'h2;

  // Request from the programming front end.
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [1:0] sel;
    logic [1:0] addr;
    logic [7:0] data;
  } prog_req_t;

  // Answer toward the programming front end.
  typedef struct packed {
    logic ack;
    logic refused;
    logic [7:0] data;
  } prog_rsp_t;

  // Memory permissions derived from the lock mode.
  typedef struct packed {
    logic mem_write_ok;
    logic mem_read_ok;
    logic fuse_write_ok;
  } lock_perm_t;

endpackage : nv_store_pkg

/* File: src/lock_fuse_signature_store.sv */
`timescale 1ns/10ps
// Contract
// [R1] Two lock bits, 1 unprogrammed; only chip erase returns them to one.
// [R2] Lock byte: lock bit two at bit 1, one at bit 0; others read 1.
// [R3] Lock bits 11: no protection, all memories and fuses accessible.
// [R4] Lock bits 10: memory writes and fuse writes blocked, reads allowed.
// [R5] Lock bits 00: memory writes, reads and fuse writes all blocked.
// [R6] Programmer should write fuses before programming any lock bit.
// [R7] Two fuse bytes; programmed fuse reads 0, unprogrammed reads 1.
// [R8] High fuse: reset disable b4, serial enable b3, retain b2, level b1, enable b0.
// [R9] Serial enable fuse unreachable for read or write in serial mode.
// [R10] After reset pin disable, programmer must use parallel programming.
// [R11] Low fuse: pll b7, osc option b6, startup b5..4, clock source b3..0.
// [R12] Retain fuse programmed: chip erase keeps EEPROM, erases flash and locks.
// [R13] Chip erase leaves all fuse bits unchanged.
// [R14] Fuse writes refused while lock bit one is programmed.
// [R15] Fuses captured on programming entry; changes act after programming exit. The code applies them only at the next programming entry or power-up.
// [R16] Retain fuse change applies immediately to a following chip erase; the code uses the old value for an erase requested the next cycle.
// [R17] Fuses also captured at each power-up in normal mode.
// [R18] Three identification bytes at 0..2, readable even when locked.
// [R19] Four calibration bytes at signature rows 0..3 for 1, 2, 4, 8 MHz.
// [R20] During reset the 1 MHz calibration byte loads the oscillator trim register.
// [R21] Chip erase releases lock bits only after flash erase fully completes.
module lock_fuse_signature_store #(
  parameter logic [7:0] ID_BYTE_0 = 8'h5A, // Arbitrary value.
  parameter logic [7:0] ID_BYTE_1 = 8'hA5, // Arbitrary value.
  parameter logic [7:0] ID_BYTE_2 = 8'h3C, // Arbitrary value.
  parameter logic [31:0] CAL_BYTES = 32'h80808080,
  parameter int ERASE_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic prog_mode_i,
  input wire logic serial_mode_i,
  input wire nv_store_pkg::prog_req_t req_i,
  input wire logic erase_done_i,
  output nv_store_pkg::prog_rsp_t rsp_o,
  output logic busy_o,
  output logic flash_erase_o,
  output logic eeprom_erase_o,
  output nv_store_pkg::lock_perm_t perm_o,
  output logic [7:0] fuse_high_o,
  output logic [7:0] fuse_low_o,
  output logic [7:0] oscillator_trim_register_o
);
  import nv_store_pkg::*;

  initial begin
    if (ERASE_CYCLES < 1) begin
      $error("ERASE_CYCLES must be at least one.");
    end
    // The erase counter is sixteen bits wide and saturates at its top value.
    if (ERASE_CYCLES > 65536) begin
      $error("ERASE_CYCLES must not exceed 65536.");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_RELEASE} erase_state_t;

  // Level inputs from pins pass two flip-flops before use.
  logic prog_meta_q, prog_sync_q, prog_prev_q;
  logic ser_meta_q, ser_sync_q;
  logic [7:0] memory_lock_byte_q;
  logic [7:0] config_fuse_high_q;
  logic [7:0] config_fuse_low_q;
  logic [7:0] fuse_high_act_q, fuse_low_act_q;
  logic eeprom_retain_live_q;
  erase_state_t erase_state_q;
  logic [15:0] erase_cnt_q;
  logic power_up_q;
  prog_rsp_t rsp_q;
  lock_perm_t perm_q;
  logic lock_bit_one, lock_bit_two, fuse_ok;
  logic [7:0] ser_mask;
  logic [7:0] cal_row [4];
  logic [7:0] fuse_high_wr;
  logic [7:0] lock_wr;
  logic take_any, take_erase, take_lock, take_fuse;
  logic take_fuse_high, take_fuse_low, capture;

  // Mode 01 is not a documented mode; it keeps memories closed and leaves fuses open.
  function automatic lock_perm_t lock_perm(input logic lb2, input logic lb1);
    lock_perm_t p;
    unique case ({lb2, lb1})
      2'b11: begin
        p = '{mem_write_ok: 1'b1, mem_read_ok: 1'b1, fuse_write_ok: 1'b1}; // [R3]
      end
      2'b10: begin
        p = '{mem_write_ok: 1'b0, mem_read_ok: 1'b1, fuse_write_ok: 1'b0}; // [R4] [R14]
      end
      2'b00: begin
        p = '{mem_write_ok: 1'b0, mem_read_ok: 1'b0, fuse_write_ok: 1'b0}; // [R5] [R14]
      end
      default: begin
        p = '{mem_write_ok: 1'b0, mem_read_ok: 1'b0, fuse_write_ok: 1'b1};
      end
    endcase
    return p;
  endfunction : lock_perm

  // Shared request decode: a command counts only in synced programming mode with erase idle.
  function automatic logic cmd_taken(input logic in_prog, input logic valid,
                                     input erase_state_t st, input logic [7:0] cmd,
                                     input logic [7:0] code);
    return in_prog && valid && st == ST_IDLE && cmd == code;
  endfunction : cmd_taken

  // Identification bytes by row index; the fourth row is not populated and reads zero.
  function automatic logic [7:0] id_byte(input logic [1:0] addr);
    unique case (addr)
      ID_ADDR_0: return ID_BYTE_0; // [R18]
      ID_ADDR_1: return ID_BYTE_1; // [R18]
      ID_ADDR_2: return ID_BYTE_2; // [R18]
      default: return 8'h00;
    endcase
  endfunction : id_byte

  // Only the later stages are read by logic; the first one may still be settling.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_meta_q <= 1'b0;
      prog_sync_q <= 1'b0;
      prog_prev_q <= 1'b0;
    end else begin
      prog_meta_q <= prog_mode_i;
      prog_sync_q <= prog_meta_q;
      prog_prev_q <= prog_sync_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_meta_q <= 1'b0;
      ser_sync_q <= 1'b0;
    end else begin
      ser_meta_q <= serial_mode_i;
      ser_sync_q <= ser_meta_q;
    end
  end

  assign lock_bit_one = memory_lock_byte_q[LOCK_BIT_ONE_POS];
  assign lock_bit_two = memory_lock_byte_q[LOCK_BIT_TWO_POS];
  assign fuse_ok = lock_bit_one; // [R14]
  // In serial mode the serial enable fuse bit is hidden from read and write.
  assign ser_mask = ser_sync_q ? ~(8'h01 << SERIAL_PROG_ENABLE_POS) : 8'hFF; // [R9]

  // Requests that arrive during an erase get no answer at all, so a programmer
  // has to watch busy rather than count on a refusal.
  assign take_any = prog_sync_q && req_i.valid && erase_state_q == ST_IDLE;
  assign take_erase = cmd_taken(prog_sync_q, req_i.valid, erase_state_q, req_i.cmd,
                                CMD_CHIP_ERASE);
  assign take_lock = cmd_taken(prog_sync_q, req_i.valid, erase_state_q, req_i.cmd,
                               CMD_WRITE_LOCK);
  assign take_fuse = cmd_taken(prog_sync_q, req_i.valid, erase_state_q, req_i.cmd,
                               CMD_WRITE_FUSE) && fuse_ok; // [R14]
  assign take_fuse_high = take_fuse && req_i.sel == SEL_FUSE_HIGH;
  assign take_fuse_low = take_fuse && req_i.sel == SEL_FUSE_LOW;

  // The calibration row is an array so one index picks any of the four bytes.
  for (genvar g = 0; g < 4; g++) begin : g_cal_row
    assign cal_row[g] = CAL_BYTES[8*g +: 8]; // [R19]
  end

  // Lock merge per bit: a write can only clear a lock bit, unused bits stay 1.
  for (genvar b = 0; b < 8; b++) begin : g_lock_bit
    if (LOCK_UNUSED_MASK[b]) begin : g_unused
      assign lock_wr[b] = 1'b1; // [R2]
    end else begin : g_used
      assign lock_wr[b] = memory_lock_byte_q[b] & req_i.data[b]; // [R1]
    end
  end

  // High fuse merge per bit: unused bits stay 1 and a hidden bit keeps its value.
  for (genvar b = 0; b < 8; b++) begin : g_fuse_high_bit
    if (FUSE_HIGH_UNUSED_MASK[b]) begin : g_unused
      assign fuse_high_wr[b] = 1'b1; // [R8]
    end else begin : g_used
      assign fuse_high_wr[b] = ser_mask[b] ? req_i.data[b] : config_fuse_high_q[b]; // [R9]
    end
  end

  // Capture at the first cycle after reset outside programming, or on entry into it.
  assign capture = (power_up_q && !prog_sync_q) || (prog_sync_q && !prog_prev_q);

  // Lock byte: only chip erase can raise bits back to one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_lock_byte_q <= LOCK_RESET;
    end else if (erase_state_q == ST_RELEASE) begin
      memory_lock_byte_q <= LOCK_RESET; // [R1] [R21]
    end else if (take_lock) begin
      memory_lock_byte_q <= lock_wr; // [R1] [R2]
    end
  end

  // Stored fuse bytes; chip erase never touches them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_fuse_high_q <= FUSE_HIGH_RESET; // [R8]
      config_fuse_low_q <= FUSE_LOW_RESET; // [R11]
    end else if (take_fuse_high) begin // [R13] [R14]
      config_fuse_high_q <= fuse_high_wr; // [R7] [R8] [R9]
    end else if (take_fuse_low) begin // [R14]
      // The low fuse has no unused bits, so a write stores all eight.
      config_fuse_low_q <= req_i.data; // [R7] [R11]
    end
  end

  // Active fuse copies: captured at power-up and on programming entry.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_up_q <= 1'b1;
      fuse_high_act_q <= FUSE_HIGH_RESET;
      fuse_low_act_q <= FUSE_LOW_RESET;
    end else begin
      power_up_q <= 1'b0;
      if (capture) begin
        fuse_high_act_q <= config_fuse_high_q; // [R15] [R17]
        fuse_low_act_q <= config_fuse_low_q; // [R15] [R17]
      end
    end
  end

  // The retain fuse bypasses deferred capture; erase sees its stored value one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eeprom_retain_live_q <= 1'b1;
    end else begin
      eeprom_retain_live_q <= config_fuse_high_q[EEPROM_RETAIN_POS]; // [R16]
    end
  end

  // Chip erase sequence; locks release only after flash erase completes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_state_q <= ST_IDLE;
      erase_cnt_q <= 16'h0000;
    end else begin
      unique case (erase_state_q)
        ST_IDLE: begin
          if (take_erase) begin
            erase_state_q <= ST_ERASE;
            erase_cnt_q <= 16'h0000;
          end
        end
        ST_ERASE: begin
          // Saturating rather than wrapping, so a late done never looks early.
          if (erase_cnt_q != 16'hFFFF) begin
            erase_cnt_q <= erase_cnt_q + 16'h0001;
          end
          if (erase_done_i && erase_cnt_q >= 16'(ERASE_CYCLES - 1)) begin
            erase_state_q <= ST_RELEASE; // [R21]
          end
        end
        ST_RELEASE: begin
          erase_state_q <= ST_IDLE;
        end
        // The fourth code of the state register is unused; recover to idle from it.
        default: begin
          erase_state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      flash_erase_o <= 1'b0;
      eeprom_erase_o <= 1'b0;
    end else begin
      // Busy stays high one cycle past the lock release, so a programmer that
      // waits for it low never sees the old locks.
      busy_o <= (erase_state_q != ST_IDLE) || take_erase;
      flash_erase_o <= take_erase; // [R12]
      eeprom_erase_o <= take_erase && eeprom_retain_live_q; // [R12] [R16]
    end
  end

  // Answers to programmer requests; one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= '0;
      if (take_any) begin
        // Writes answer with zero data; only the refusal flag carries news.
        rsp_q.ack <= 1'b1;
        unique case (req_i.cmd)
          CMD_READ_SIG: begin
            if (req_i.sel == SEL_FUSE_HIGH) begin
              rsp_q.data <= cal_row[req_i.addr]; // [R19]
            end else begin
              rsp_q.data <= id_byte(req_i.addr); // [R18]
            end
          end
          CMD_READ_FUSE_LOCK: begin
            if (req_i.sel == SEL_LOCK) begin
              rsp_q.data <= memory_lock_byte_q; // [R2]
            end else if (req_i.sel == SEL_FUSE_HIGH) begin
              rsp_q.data <= config_fuse_high_q & ser_mask; // [R7] [R9]
            end else begin
              rsp_q.data <= config_fuse_low_q; // [R7]
            end
          end
          CMD_WRITE_FUSE: rsp_q.refused <= !fuse_ok; // [R14]
          CMD_WRITE_FLASH, CMD_WRITE_EEPROM: rsp_q.refused <= !perm_q.mem_write_ok; // [R4]
          CMD_READ_FLASH, CMD_READ_EEPROM: rsp_q.refused <= !perm_q.mem_read_ok; // [R5]
          default: rsp_q.refused <= 1'b0;
        endcase
      end
    end
  end
  assign rsp_o = rsp_q;

  // Permissions trail a lock write by one cycle; fuse writes use the live lock bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      perm_q <= lock_perm(1'b1, 1'b1);
    end else begin
      perm_q <= lock_perm(lock_bit_two, lock_bit_one);
    end
  end
  assign perm_o = perm_q;
  assign fuse_high_o = fuse_high_act_q;
  assign fuse_low_o = fuse_low_act_q;

  // Only the 1 MHz value is loaded; software loads the others.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oscillator_trim_register_o <= cal_row[CAL_ADDR_1MHZ]; // [R20]
    end
  end

endmodule : lock_fuse_signature_store

/* File: testbench/erase_memory_model.sv */
`timescale 1ns/10ps
// Flash array behind the store: reports erase completion after a chosen delay.
module erase_memory_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flash_erase_i,
  input wire logic busy_i,
  input wire logic [3:0] delay_i,
  output logic erase_done_o
);
  logic [3:0] cnt_q;

  // Done is held until busy falls so the store can never miss it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      erase_done_o <= 1'b0;
    end else if (flash_erase_i) begin
      cnt_q <= delay_i;
      erase_done_o <= 1'b0;
    end else if (cnt_q > 4'h1) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (cnt_q == 4'h1) begin
      cnt_q <= 4'h0;
      erase_done_o <= 1'b1;
    end else if (!busy_i) begin
      erase_done_o <= 1'b0;
    end
  end
endmodule : erase_memory_model

/* File: testbench/lock_fuse_signature_store_monitor.sv */
`timescale 1ns/10ps
module lock_fuse_signature_store_monitor
  import nv_store_pkg::*;
#(
  parameter logic [31:0] CAL_BYTES = 32'h80808080
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic prog_mode_i,
  input wire logic serial_mode_i,
  input wire nv_store_pkg::prog_req_t req_i,
  input wire logic erase_done_i,
  input wire nv_store_pkg::prog_rsp_t rsp_o,
  input wire logic busy_o,
  input wire logic flash_erase_o,
  input wire logic eeprom_erase_o,
  input wire nv_store_pkg::lock_perm_t perm_o,
  input wire logic [7:0] fuse_high_o,
  input wire logic [7:0] fuse_low_o,
  input wire logic [7:0] oscillator_trim_register_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_trim_reset: assert property (disable iff (1'b0)
    rst_i |=> oscillator_trim_register_o == CAL_BYTES[7:0]) else $error("trim not loaded");
  a_trim_hold: assert property (
    1'b1 |=> $stable(oscillator_trim_register_o)) else $error("trim changed");
  a_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> perm_o == 3'b111 && !busy_o && rsp_o == '0) else $error("bad reset state");
  a_erase_start: assert property (
    prog_mode_i [*3] ##0 (req_i.valid && req_i.cmd == CMD_CHIP_ERASE && !busy_o)
    |=> busy_o && flash_erase_o && rsp_o.ack) else $error("erase not started");
  a_erase_waits: assert property (
    busy_o && !erase_done_i |=> busy_o) else $error("erase ended early");
  a_erase_keeps: assert property (
    busy_o |=> $stable(fuse_high_o) && $stable(fuse_low_o)) else $error("fuses moved");
  a_fuse_refused: assert property (
    prog_mode_i [*3] ##0 (req_i.valid && req_i.cmd == CMD_WRITE_FUSE && !busy_o
    && !perm_o.fuse_write_ok) |=> rsp_o.ack && rsp_o.refused) else $error("fuse write taken");
  a_read_refused: assert property (
    prog_mode_i [*3] ##0 (req_i.valid && req_i.cmd == CMD_READ_FLASH && !busy_o
    && !perm_o.mem_read_ok) |=> rsp_o.ack && rsp_o.refused) else $error("read not refused");
  a_perm_order: assert property (
    !perm_o.fuse_write_ok |-> !perm_o.mem_write_ok) else $error("bad permission mix");
  a_prog_stable: assert property (
    prog_mode_i [*5] |-> $stable(fuse_high_o) && $stable(fuse_low_o)) else $error("fuse early");
  a_refused_acked: assert property (
    rsp_o.refused |-> rsp_o.ack) else $error("refusal without ack");
endmodule : lock_fuse_signature_store_monitor

bind lock_fuse_signature_store lock_fuse_signature_store_monitor #(.CAL_BYTES(CAL_BYTES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .prog_mode_i(prog_mode_i), .serial_mode_i(serial_mode_i),
  .req_i(req_i), .erase_done_i(erase_done_i), .rsp_o(rsp_o), .busy_o(busy_o),
  .flash_erase_o(flash_erase_o), .eeprom_erase_o(eeprom_erase_o), .perm_o(perm_o),
  .fuse_high_o(fuse_high_o), .fuse_low_o(fuse_low_o),
  .oscillator_trim_register_o(oscillator_trim_register_o));

/* File: testbench/lock_fuse_signature_store_bench.sv */
`timescale 1ns/10ps
module lock_fuse_signature_store_bench;
  import nv_store_pkg::*;
  // Identification values are arbitrary.
  localparam logic [23:0] IDS = 24'h654321;
  localparam logic [31:0] CAL = 32'h44332211;
  logic clk_i, rst_i, pm, sm, done, busy, fe, ee, rf;
  logic [3:0] dly;
  logic [7:0] fh, fl, trim, rd, lo, hi;
  prog_req_t req;
  prog_rsp_t rsp;
  lock_perm_t perm;
  int n_errors = 0, total_checks = 0, seed = 56584, n_ee = 0, k;

  lock_fuse_signature_store #(.ID_BYTE_0(IDS[7:0]), .ID_BYTE_1(IDS[15:8]),
    .ID_BYTE_2(IDS[23:16]), .CAL_BYTES(CAL), .ERASE_CYCLES(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .prog_mode_i(pm), .serial_mode_i(sm), .req_i(req),
    .erase_done_i(done), .rsp_o(rsp), .busy_o(busy), .flash_erase_o(fe), .eeprom_erase_o(ee),
    .perm_o(perm), .fuse_high_o(fh), .fuse_low_o(fl), .oscillator_trim_register_o(trim));
  erase_memory_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .flash_erase_i(fe), .busy_i(busy),
    .delay_i(dly), .erase_done_o(done));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (ee === 1'b1) n_ee <= n_ee + 1;

  task test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task op(input logic [7:0] c, input logic [1:0] s, input logic [1:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    req <= '{1'b1, c, s, a, d};
    @(posedge clk_i);
    req.valid <= 1'b0;
    #1;
    for (i = 0; i < 8 && rsp.ack !== 1'b1; i++) tick(1);
    if (i == 8) begin
      n_errors++;
      test_done();
    end
    rd = rsp.data;
    rf = rsp.refused;
  endtask : op
  // Waiting on busy matters: the store ignores requests while erasing.
  task erase;
    int i;
    dly <= 4'(($random(seed) & 7) + 1);
    op(CMD_CHIP_ERASE, 2'h0, 2'h0, 8'h00);
    for (i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
    if (i == 100) begin
      n_errors++;
      test_done();
    end
  endtask : erase

  initial begin
    rst_i = 1'b1; pm = 1'b0; sm = 1'b0; dly = 4'h1; req = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(trim, 8'h11);
    chk(fh, 8'hF7);
    chk(fl, 8'hE1);
    chk({5'h00, perm}, 8'h07);
    pm <= 1'b1;
    tick(4);
    for (k = 0; k < 3; k++) begin
      op(CMD_READ_SIG, 2'h0, k[1:0], 8'h00);
      chk(rd, IDS[8*k +: 8]);
    end
    for (k = 0; k < 4; k++) begin
      op(CMD_READ_SIG, 2'h1, k[1:0], 8'h00);
      chk(rd, CAL[8*k +: 8]);
    end
    op(CMD_READ_FUSE_LOCK, SEL_LOCK, 2'h0, 8'h00);
    chk(rd, 8'hFF);
    lo = 8'($random(seed));
    hi = 8'hF0 | (8'($random(seed)) & 8'h0F);
    op(CMD_WRITE_FUSE, SEL_FUSE_LOW, 2'h0, lo);
    op(CMD_WRITE_FUSE, SEL_FUSE_HIGH, 2'h0, hi);
    op(CMD_READ_FUSE_LOCK, SEL_FUSE_LOW, 2'h0, 8'h00);
    chk(rd, lo);
    op(CMD_READ_FUSE_LOCK, SEL_FUSE_HIGH, 2'h0, 8'h00);
    chk(rd, hi);
    chk(fh, 8'hF7);
    sm <= 1'b1;
    tick(3);
    op(CMD_READ_FUSE_LOCK, SEL_FUSE_HIGH, 2'h0, 8'h00);
    chk(rd, hi & 8'hF7);
    op(CMD_WRITE_FUSE, SEL_FUSE_HIGH, 2'h0, hi ^ 8'h08);
    sm <= 1'b0;
    pm <= 1'b0;
    tick(5);
    pm <= 1'b1;
    tick(5);
    chk(fh, hi);
    chk(fl, lo);
    op(CMD_READ_FUSE_LOCK, SEL_FUSE_HIGH, 2'h0, 8'h00);
    chk(rd, hi);
    op(CMD_WRITE_FUSE, SEL_FUSE_HIGH, 2'h0, 8'hFB);
    erase();
    chk(n_ee[7:0], 8'h00);
    op(CMD_WRITE_FUSE, SEL_FUSE_HIGH, 2'h0, 8'hFF);
    erase();
    chk(n_ee[7:0], 8'h01);
    op(CMD_READ_FUSE_LOCK, SEL_FUSE_HIGH, 2'h0, 8'h00);
    chk(rd, 8'hFF);
    op(CMD_WRITE_LOCK, SEL_LOCK, 2'h0, 8'hFE);
    op(CMD_WRITE_LOCK, SEL_LOCK, 2'h0, 8'hFF);
    op(CMD_READ_FUSE_LOCK, SEL_LOCK, 2'h0, 8'h00);
    chk(rd, 8'hFE);
    chk({5'h00, perm}, 8'h02);
    op(CMD_WRITE_FUSE, SEL_FUSE_LOW, 2'h0, 8'hE1);
    chk({7'h00, rf}, 8'h01);
    op(CMD_WRITE_FLASH, 2'h0, 2'h0, 8'h00);
    chk({7'h00, rf}, 8'h01);
    op(CMD_READ_FLASH, 2'h0, 2'h0, 8'h00);
    chk({7'h00, rf}, 8'h00);
    op(CMD_WRITE_LOCK, SEL_LOCK, 2'h0, 8'hFC);
    op(CMD_READ_EEPROM, 2'h0, 2'h0, 8'h00);
    chk({7'h00, rf}, 8'h01);
    chk({5'h00, perm}, 8'h00);
    op(CMD_READ_FLASH, 2'h0, 2'h0, 8'h00);
    chk({7'h00, rf}, 8'h01);
    op(CMD_READ_SIG, 2'h0, 2'h2, 8'h00);
    chk(rd, IDS[23:16]);
    erase();
    op(CMD_READ_FUSE_LOCK, SEL_LOCK, 2'h0, 8'h00);
    chk(rd, 8'hFF);
    op(CMD_WRITE_EEPROM, 2'h0, 2'h0, 8'h00);
    chk({7'h00, rf}, 8'h00);
    test_done();
  end
endmodule : lock_fuse_signature_store_bench
